// file: iwr_pkg.sv
// constants and carrier types of the interrupt, wake-up and reset-cause block
// assumes a single instruction clock shared by core, block and watchdog
package iwr_pkg;

  // ----------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------
  localparam int IWR_PORT_W = 8;
  localparam int IWR_NSRC = 3;
  localparam int IWR_ADDR_W = 10;

  // ----------------------------------------------------------------------
  // flag and mask bit positions
  // ----------------------------------------------------------------------
  localparam int IWR_BIT_TICK = 0;
  localparam int IWR_BIT_CHG = 1;
  localparam int IWR_BIT_EXT = 2;

  // ----------------------------------------------------------------------
  // vectors
  // ----------------------------------------------------------------------
  localparam logic [IWR_ADDR_W-1:0] IWR_VEC_IRQ = 10'h008;
  localparam logic [IWR_ADDR_W-1:0] IWR_VEC_SOFT = 10'h001;

  // ----------------------------------------------------------------------
  // reset values and ext pin select mask
  // ----------------------------------------------------------------------
  localparam logic [IWR_NSRC-1:0] IWR_FLAG_RST = 3'h0;
  localparam logic [IWR_NSRC-1:0] IWR_MASK_RST = 3'h0;
  localparam logic IWR_TO_RST = 1'b1;
  localparam logic IWR_PD_RST = 1'b1;
  localparam logic [IWR_PORT_W-1:0] IWR_PORT_RST = 8'h00;
  localparam logic [IWR_PORT_W-1:0] IWR_EXT_PIN_SEL = 8'h01;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic wdt_clear;
    logic power_down;
    logic irq_on;
    logic irq_off;
    logic return_from_irq_op;
    logic soft_irq;
  } iwr_ops_t;

  typedef struct packed {
    logic valid;
    logic [IWR_ADDR_W-1:0] addr;
  } iwr_vec_t;

endpackage

// file: iwr_sync.sv
// two flip-flop synchroniser for a group of pin levels
// assumes pins are asynchronous to i_clk
`timescale 1ns/100ps
module iwr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // pins in, levels out
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_reg <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end

endmodule

// file: iwr_irq_wake_reset.sv
// interrupt flags, mask, global enable, vectoring, sleep wake-up and
// time-out / power-down reset-cause flags
// assumes core ops arrive as one-cycle pulses on i_clk; port and clear pin
// are asynchronous pins; watchdog time-out is a one-cycle pulse on i_clk
//
// What this block does
// - reset on power-on, clear pin pulse, watchdog
// - clear pin while running keeps both flags
// - clear pin wakes sleep: timeout 1, powerdown 0
// - watchdog while running: timeout 0, powerdown kept
// - watchdog wakes sleep: both flags 0
// - port change wakes sleep: timeout 1, powerdown 0
// - flag effects of power-on, clear op, sleep op
// - three sources: tick overflow, port change, pin falling edge
// - outputs and selected pin bit0 excluded
// - change wakes only if enabled before sleep
// - wake continues, or vectors 008H if enabled
// - per-source flag bits and per-source mask bits
// - enable op sets, disable op clears global
// - enabled interrupt fetches from 008H
// - non-change flags set regardless of masks
// - flag read returns flags AND mask
// - return op sets global enable like enable op
// - enabled software interrupt fetches from 001H
`timescale 1ns/100ps
module iwr_irq_wake_reset (
  // clock and power-on reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // pins
  input wire logic i_clear_pin_n,
  input wire logic [iwr_pkg::IWR_PORT_W-1:0] i_port,
  // port configuration
  input wire logic [iwr_pkg::IWR_PORT_W-1:0] i_port_is_out,
  input wire logic i_ext_pin_sel,
  input wire logic i_port_read,
  // event sources
  input wire logic i_tick_overflow,
  input wire logic i_wdt_timeout,
  // core ops
  input wire iwr_pkg::iwr_ops_t i_ops,
  // flag and mask register writes
  input wire logic i_flag_wr,
  input wire logic [iwr_pkg::IWR_NSRC-1:0] i_flag_wdata,
  input wire logic i_mask_wr,
  input wire logic [iwr_pkg::IWR_NSRC-1:0] i_mask_wdata,
  // status
  output logic [iwr_pkg::IWR_NSRC-1:0] o_flag_rdata,
  output logic [iwr_pkg::IWR_NSRC-1:0] o_mask,
  output logic o_global_en,
  output logic o_timeout_flag,
  output logic o_power_down_flag,
  output logic o_sleeping,
  // to core
  output iwr_pkg::iwr_vec_t o_vector,
  output logic o_resume,
  output logic o_core_reset
);
  import iwr_pkg::*;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [IWR_PORT_W:0] pins_s;
  logic [IWR_PORT_W-1:0] port_s;
  logic clr_s;

  iwr_sync #(
    .W(IWR_PORT_W + 1),
    .RST_VAL({1'b1, IWR_PORT_RST})
  ) u_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_async({i_clear_pin_n, i_port}),
    .o_sync(pins_s)
  );

  assign port_s = pins_s[IWR_PORT_W-1:0];
  assign clr_s = pins_s[IWR_PORT_W];

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic clr_low_reg;
  logic ext_prev_reg;
  logic [IWR_PORT_W-1:0] cmp_reg;
  logic [IWR_NSRC-1:0] flag_reg;
  logic [IWR_NSRC-1:0] flag_next;
  logic [IWR_NSRC-1:0] mask_reg;
  logic [IWR_NSRC-1:0] mask_next;
  logic gie_reg;
  logic sleep_reg;
  logic wake_en_reg;
  logic to_reg;
  logic pd_reg;

  // ----------------------------------------------------------------------
  // event decode
  // ----------------------------------------------------------------------
  logic clr_evt;
  logic soft_rst;
  logic [IWR_PORT_W-1:0] elig;
  logic chg;
  logic ext_fall;
  logic [IWR_NSRC-1:0] set_vec;
  logic pending;
  logic wake;
  logic vec_take;
  logic soft_take;

  assign clr_evt = clr_low_reg & clr_s;
  assign soft_rst = clr_evt | i_wdt_timeout;
  assign elig = ~i_port_is_out & ~(i_ext_pin_sel ? IWR_EXT_PIN_SEL
                                                 : IWR_PORT_RST);
  assign chg = |((port_s ^ cmp_reg) & elig);
  assign ext_fall = i_ext_pin_sel & ext_prev_reg & ~port_s[0];

  always_comb begin
    set_vec = IWR_FLAG_RST;
    set_vec[IWR_BIT_TICK] = i_tick_overflow;
    set_vec[IWR_BIT_CHG] = chg & mask_reg[IWR_BIT_CHG];
    set_vec[IWR_BIT_EXT] = ext_fall;
  end

  assign pending = |(flag_reg & mask_reg);
  assign wake = sleep_reg & chg & wake_en_reg;
  assign vec_take = gie_reg & pending & ~sleep_reg & ~soft_rst;
  assign soft_take = gie_reg & i_ops.soft_irq & ~pending & ~sleep_reg
                     & ~soft_rst;

  // ----------------------------------------------------------------------
  // clear pin pulse and ext pin edge tracking
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      clr_low_reg <= 1'b0;
    end else begin
      clr_low_reg <= ~clr_s;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= port_s[0];
    end
  end

  // comparison value follows a port read
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cmp_reg <= IWR_PORT_RST;
    end else if (i_port_read) begin
      cmp_reg <= port_s;
    end
  end

  // ----------------------------------------------------------------------
  // flags and mask
  // ----------------------------------------------------------------------
  always_comb begin
    flag_next = i_flag_wr ? i_flag_wdata : flag_reg;
    flag_next = flag_next | set_vec;
    if (soft_rst) begin
      flag_next = IWR_FLAG_RST;
    end
    mask_next = i_mask_wr ? i_mask_wdata : mask_reg;
    if (soft_rst) begin
      mask_next = IWR_MASK_RST;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      flag_reg <= IWR_FLAG_RST;
    end else begin
      flag_reg <= flag_next;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mask_reg <= IWR_MASK_RST;
    end else begin
      mask_reg <= mask_next;
    end
  end

  // ----------------------------------------------------------------------
  // global enable
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      gie_reg <= 1'b0;
    end else if (soft_rst || vec_take || soft_take) begin
      gie_reg <= 1'b0;
    end else if (i_ops.irq_on || i_ops.return_from_irq_op) begin
      gie_reg <= 1'b1;
    end else if (i_ops.irq_off) begin
      gie_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // sleep and wake enable
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sleep_reg <= 1'b0;
    end else if (soft_rst || wake) begin
      sleep_reg <= 1'b0;
    end else if (i_ops.power_down) begin
      sleep_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wake_en_reg <= 1'b0;
    end else if (i_ops.power_down && !sleep_reg) begin
      wake_en_reg <= mask_reg[IWR_BIT_CHG];
    end
  end

  // ----------------------------------------------------------------------
  // time-out and power-down flags
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      to_reg <= IWR_TO_RST;
      pd_reg <= IWR_PD_RST;
    end else if (i_wdt_timeout) begin
      to_reg <= 1'b0;
      if (sleep_reg) begin
        pd_reg <= 1'b0;
      end
    end else if (clr_evt) begin
      if (sleep_reg) begin
        to_reg <= 1'b1;
        pd_reg <= 1'b0;
      end
    end else if (wake) begin
      to_reg <= 1'b1;
      pd_reg <= 1'b0;
    end else if (i_ops.wdt_clear) begin
      to_reg <= 1'b1;
      pd_reg <= 1'b1;
    end else if (i_ops.power_down) begin
      to_reg <= 1'b1;
      pd_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_vector <= '0;
    end else begin
      o_vector.valid <= vec_take | soft_take;
      o_vector.addr <= soft_take ? IWR_VEC_SOFT : IWR_VEC_IRQ;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_resume <= 1'b0;
    end else begin
      o_resume <= wake & ~gie_reg & ~soft_rst;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_core_reset <= 1'b1;
    end else begin
      o_core_reset <= ~clr_s | soft_rst;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_flag_rdata <= IWR_FLAG_RST;
      o_mask <= IWR_MASK_RST;
    end else begin
      o_flag_rdata <= flag_next & mask_next;
      o_mask <= mask_next;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_global_en <= 1'b0;
      o_timeout_flag <= IWR_TO_RST;
      o_power_down_flag <= IWR_PD_RST;
      o_sleeping <= 1'b0;
    end else begin
      o_global_en <= gie_reg;
      o_timeout_flag <= to_reg;
      o_power_down_flag <= pd_reg;
      o_sleeping <= sleep_reg;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_clr_run_keeps;
    @(posedge i_clk) disable iff (!i_reset_n)
    (clr_evt && !sleep_reg && !i_wdt_timeout) |=>
      (to_reg == $past(to_reg) && pd_reg == $past(pd_reg));
  endproperty
  a_clr_run_keeps: assert property (p_clr_run_keeps)
    else $error("clear pin while running changed reset-cause flags");

  property p_clr_sleep;
    @(posedge i_clk) disable iff (!i_reset_n)
    (clr_evt && sleep_reg && !i_wdt_timeout) |=> (to_reg && !pd_reg);
  endproperty
  a_clr_sleep: assert property (p_clr_sleep)
    else $error("clear pin wake did not give timeout 1 powerdown 0");

  property p_wdt_run;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_wdt_timeout && !sleep_reg) |=> (!to_reg && pd_reg == $past(pd_reg));
  endproperty
  a_wdt_run: assert property (p_wdt_run)
    else $error("watchdog while running set wrong flags");

  property p_wdt_sleep;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_wdt_timeout && sleep_reg) |=> (!to_reg && !pd_reg);
  endproperty
  a_wdt_sleep: assert property (p_wdt_sleep)
    else $error("watchdog wake did not clear both flags");

  property p_chg_wake;
    @(posedge i_clk) disable iff (!i_reset_n)
    (wake && !soft_rst) |=> (to_reg && !pd_reg && !sleep_reg);
  endproperty
  a_chg_wake: assert property (p_chg_wake)
    else $error("port change wake flags or sleep state wrong");

  property p_sleep_op;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_ops.power_down && !soft_rst && !wake && !i_ops.wdt_clear) |=>
      (to_reg && !pd_reg && sleep_reg);
  endproperty
  a_sleep_op: assert property (p_sleep_op)
    else $error("sleep op did not give timeout 1 powerdown 0");

  property p_no_wake_unarmed;
    @(posedge i_clk) disable iff (!i_reset_n)
    (sleep_reg && !wake_en_reg && !soft_rst) |=> sleep_reg;
  endproperty
  a_no_wake_unarmed: assert property (p_no_wake_unarmed)
    else $error("woke on port change without prior enable");

  property p_resume_path;
    @(posedge i_clk) disable iff (!i_reset_n)
    (wake && !soft_rst) |=> (o_resume != $past(gie_reg));
  endproperty
  a_resume_path: assert property (p_resume_path)
    else $error("wake took wrong path for global enable state");

  property p_vector_irq;
    @(posedge i_clk) disable iff (!i_reset_n)
    vec_take |=> (o_vector.valid && o_vector.addr == 10'h008 && !gie_reg);
  endproperty
  a_vector_irq: assert property (p_vector_irq)
    else $error("interrupt did not vector to 008H and drop enable");

  property p_vector_soft;
    @(posedge i_clk) disable iff (!i_reset_n)
    soft_take |=> (o_vector.valid && o_vector.addr == 10'h001);
  endproperty
  a_vector_soft: assert property (p_vector_soft)
    else $error("software interrupt did not vector to 001H");

  property p_tick_sets;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_tick_overflow && !soft_rst) |=> flag_reg[IWR_BIT_TICK];
  endproperty
  a_tick_sets: assert property (p_tick_sets)
    else $error("tick overflow flag not set regardless of masks");

  property p_read_and;
    @(posedge i_clk) disable iff (!i_reset_n)
    ##1 (o_flag_rdata == (flag_reg & mask_reg));
  endproperty
  a_read_and: assert property (p_read_and)
    else $error("flag read is not flags AND mask");

  property p_return_from_irq_op_enables;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_ops.return_from_irq_op && !soft_rst && !vec_take && !soft_take) |=> gie_reg;
  endproperty
  a_return_from_irq_op_enables: assert property (p_return_from_irq_op_enables)
    else $error("return op did not set global enable");

  property p_off_disables;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_ops.irq_off && !i_ops.irq_on && !i_ops.return_from_irq_op) |=> !gie_reg;
  endproperty
  a_off_disables: assert property (p_off_disables)
    else $error("disable op left global enable on");

endmodule

// file: iwr_far_model.sv
// far-side model: core sequencer issuing ops, change-port pins, fetch log
// assumes o_vector and o_resume of the block are sampled on i_clk
`timescale 1ns/100ps
module iwr_far_model (
  // clock
  input wire logic i_clk,
  // from block
  input wire iwr_pkg::iwr_vec_t i_vector,
  input wire logic i_resume,
  // to block
  output iwr_pkg::iwr_ops_t o_ops,
  output logic [iwr_pkg::IWR_PORT_W-1:0] o_port
);
  import iwr_pkg::*;
  int vec_count;
  int resume_count;
  logic [IWR_ADDR_W-1:0] vec_addr;

  // ----------------------------------------------------------------------
  // idle state
  // ----------------------------------------------------------------------
  initial begin
    o_ops = '0;
    o_port = IWR_PORT_RST;
    vec_count = 0;
    resume_count = 0;
    vec_addr = '0;
  end

  // ----------------------------------------------------------------------
  // core fetch redirection log
  // ----------------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_vector.valid === 1'b1) begin
      vec_count++;
      vec_addr = i_vector.addr;
    end
    if (i_resume === 1'b1) begin
      resume_count++;
    end
  end

  // ----------------------------------------------------------------------
  // one-cycle op pulse and pin update, just after a rising edge
  // ----------------------------------------------------------------------
  task automatic issue(input iwr_ops_t v);
    @(posedge i_clk);
    #1;
    o_ops = v;
    @(posedge i_clk);
    #1;
    o_ops = '0;
  endtask

  task automatic pins(input logic [IWR_PORT_W-1:0] v);
    @(posedge i_clk);
    #1;
    o_port = v;
  endtask
endmodule

// file: irq_wake_reset_status_test.sv
// testbench: op, strobe and pin sequences with expected flags and fetches
// assumes iwr_far_model plays the core and the port pins
`timescale 1ns/100ps
module irq_wake_reset_status_test;
  import iwr_pkg::*;
  localparam iwr_ops_t OP_WATCHDOG_CLEAR_OP = 6'h20;
  localparam iwr_ops_t OP_PD = 6'h10;
  localparam iwr_ops_t OP_ON = 6'h08;
  localparam iwr_ops_t OP_OFF = 6'h04;
  localparam iwr_ops_t OP_RETURN_FROM_IRQ_OP = 6'h02;
  localparam iwr_ops_t OP_SOFT = 6'h01;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_clear_pin_n = 1'b1;
  logic [IWR_PORT_W-1:0] i_port_is_out = 8'h00;
  logic i_ext_pin_sel = 1'b0;
  logic i_port_read = 1'b0;
  logic i_tick_overflow = 1'b0;
  logic i_wdt_timeout = 1'b0;
  logic i_flag_wr = 1'b0;
  logic [IWR_NSRC-1:0] i_flag_wdata = 3'h0;
  logic i_mask_wr = 1'b0;
  logic [IWR_NSRC-1:0] i_mask_wdata = 3'h0;
  iwr_ops_t ops;
  logic [IWR_PORT_W-1:0] port;
  logic [IWR_NSRC-1:0] o_flag_rdata;
  logic [IWR_NSRC-1:0] o_mask;
  logic o_global_en;
  logic o_timeout_flag;
  logic o_power_down_flag;
  logic o_sleeping;
  iwr_vec_t o_vector;
  logic o_resume;
  logic o_core_reset;
  int fail_count = 0;
  int samples_checked = 0;
  int base_v;
  int base_r;

  always #2.5 i_clk = ~i_clk;

  iwr_irq_wake_reset u_iwr_irq_wake_reset (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_clear_pin_n(i_clear_pin_n),
    .i_port(port), .i_port_is_out(i_port_is_out),
    .i_ext_pin_sel(i_ext_pin_sel), .i_port_read(i_port_read),
    .i_tick_overflow(i_tick_overflow), .i_wdt_timeout(i_wdt_timeout),
    .i_ops(ops), .i_flag_wr(i_flag_wr), .i_flag_wdata(i_flag_wdata),
    .i_mask_wr(i_mask_wr), .i_mask_wdata(i_mask_wdata),
    .o_flag_rdata(o_flag_rdata), .o_mask(o_mask),
    .o_global_en(o_global_en), .o_timeout_flag(o_timeout_flag),
    .o_power_down_flag(o_power_down_flag), .o_sleeping(o_sleeping),
    .o_vector(o_vector), .o_resume(o_resume), .o_core_reset(o_core_reset));

  iwr_far_model u_iwr_far_model (
    .i_clk(i_clk), .i_vector(o_vector), .i_resume(o_resume),
    .o_ops(ops), .o_port(port));

  // ----------------------------------------------------------------------
  // compare, strobe and wait tasks
  // ----------------------------------------------------------------------
  task automatic end_of_test();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk_val(input string n, input logic [9:0] e,
                         input logic [9:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic chk_cnt(input string n, input int e, input int g);
    samples_checked++;
    if (g != e) begin
      fail_count++;
      $display("ERROR %s expected %0d seen %0d", n, e, g);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic strobe(input int k, input logic [2:0] v);
    @(posedge i_clk);
    #1;
    case (k)
      0: begin
        i_tick_overflow = 1'b1;
      end
      1: begin
        i_wdt_timeout = 1'b1;
      end
      2: begin
        i_port_read = 1'b1;
      end
      3: begin
        i_flag_wr = 1'b1;
        i_flag_wdata = v;
      end
      default: begin
        i_mask_wr = 1'b1;
        i_mask_wdata = v;
      end
    endcase
    @(posedge i_clk);
    #1;
    i_tick_overflow = 1'b0;
    i_wdt_timeout = 1'b0;
    i_port_read = 1'b0;
    i_flag_wr = 1'b0;
    i_mask_wr = 1'b0;
  endtask

  task automatic snap();
    base_v = u_iwr_far_model.vec_count;
    base_r = u_iwr_far_model.resume_count;
  endtask

  task automatic await_fetch(input int nv, input int nr,
                             input logic [9:0] a);
    int k;
    for (k = 0; k < 20 && (u_iwr_far_model.vec_count - base_v < nv ||
         u_iwr_far_model.resume_count - base_r < nr); k++) begin
      @(posedge i_clk);
    end
    if (k == 20) begin
      fail_count++;
      end_of_test();
    end
    settle((nv + nr == 0) ? 20 : 2);
    chk_cnt("vector count", nv, u_iwr_far_model.vec_count - base_v);
    chk_cnt("resume count", nr, u_iwr_far_model.resume_count - base_r);
    if (nv > 0) begin
      chk_val("vector address", a, u_iwr_far_model.vec_addr);
    end
  endtask

  task automatic chk_tps(input logic t, input logic p, input logic s);
    settle(4);
    chk_val("timeout flag", 10'(t), 10'(o_timeout_flag));
    chk_val("power-down flag", 10'(p), 10'(o_power_down_flag));
    chk_val("sleeping", 10'(s), 10'(o_sleeping));
  endtask

  task automatic chk_gen(input logic e);
    settle(3);
    chk_val("global enable", 10'(e), 10'(o_global_en));
  endtask

  task automatic chk_rd(input logic [2:0] e);
    settle(3);
    chk_val("flag read", 10'(e), 10'(o_flag_rdata));
  endtask

  task automatic clear_pin();
    i_clear_pin_n = 1'b0;
    settle(4);
    chk_val("core reset", 10'h001, 10'(o_core_reset));
    i_clear_pin_n = 1'b1;
    settle(5);
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge i_clk);
    fail_count++;
    end_of_test();
  end

  initial begin
    repeat (3) @(posedge i_clk);
    #1;
    i_reset_n = 1'b1;
    chk_tps(1'b1, 1'b1, 1'b0);
    chk_val("mask", 10'(IWR_MASK_RST), 10'(o_mask));
    chk_val("core reset", 10'h000, 10'(o_core_reset));
    chk_rd(3'h0);
    u_iwr_far_model.issue(OP_ON);
    chk_gen(1'b1);
    u_iwr_far_model.issue(OP_OFF);
    chk_gen(1'b0);
    u_iwr_far_model.issue(OP_RETURN_FROM_IRQ_OP);
    chk_gen(1'b1);
    u_iwr_far_model.issue(OP_OFF);
    strobe(0, 3'h0);
    chk_rd(3'h0);
    strobe(4, 3'h1);
    chk_rd(3'h1);
    i_ext_pin_sel = 1'b1;
    u_iwr_far_model.pins(8'h01);
    settle(4);
    u_iwr_far_model.pins(8'h00);
    settle(4);
    strobe(4, 3'h5);
    chk_rd(3'h5);
    strobe(3, 3'h6);
    chk_rd(3'h4);
    strobe(3, 3'h0);
    chk_rd(3'h0);
    u_iwr_far_model.issue(OP_ON);
    snap();
    strobe(0, 3'h0);
    await_fetch(1, 0, IWR_VEC_IRQ);
    chk_gen(1'b0);
    strobe(3, 3'h0);
    u_iwr_far_model.issue(OP_RETURN_FROM_IRQ_OP);
    snap();
    await_fetch(0, 0, IWR_VEC_IRQ);
    u_iwr_far_model.issue(OP_SOFT);
    await_fetch(1, 0, IWR_VEC_SOFT);
    chk_gen(1'b0);
    snap();
    u_iwr_far_model.issue(OP_SOFT);
    await_fetch(0, 0, IWR_VEC_SOFT);
    u_iwr_far_model.issue(OP_WATCHDOG_CLEAR_OP);
    chk_tps(1'b1, 1'b1, 1'b0);
    strobe(1, 3'h0);
    chk_tps(1'b0, 1'b1, 1'b0);
    chk_val("mask", 10'h000, 10'(o_mask));
    clear_pin();
    chk_val("core reset", 10'h000, 10'(o_core_reset));
    chk_tps(1'b0, 1'b1, 1'b0);
    i_port_is_out = 8'h20;
    strobe(2, 3'h0);
    strobe(4, 3'h2);
    u_iwr_far_model.issue(OP_PD);
    chk_tps(1'b1, 1'b0, 1'b1);
    snap();
    u_iwr_far_model.pins(8'h21);
    settle(6);
    chk_val("sleeping", 10'h001, 10'(o_sleeping));
    u_iwr_far_model.pins(8'h29);
    await_fetch(0, 1, IWR_VEC_IRQ);
    chk_tps(1'b1, 1'b0, 1'b0);
    chk_rd(3'h2);
    strobe(2, 3'h0);
    strobe(3, 3'h0);
    u_iwr_far_model.issue(OP_ON);
    u_iwr_far_model.issue(OP_PD);
    snap();
    u_iwr_far_model.pins(8'h21);
    await_fetch(1, 0, IWR_VEC_IRQ);
    strobe(2, 3'h0);
    strobe(3, 3'h0);
    strobe(4, 3'h0);
    u_iwr_far_model.issue(OP_PD);
    snap();
    u_iwr_far_model.pins(8'h29);
    await_fetch(0, 0, IWR_VEC_IRQ);
    chk_tps(1'b1, 1'b0, 1'b1);
    clear_pin();
    chk_tps(1'b1, 1'b0, 1'b0);
    u_iwr_far_model.issue(OP_PD);
    settle(3);
    strobe(1, 3'h0);
    chk_tps(1'b0, 1'b0, 1'b0);
    i_ext_pin_sel = 1'b0;
    i_port_is_out = 8'h00;
    strobe(2, 3'h0);
    strobe(4, 3'h2);
    u_iwr_far_model.pins(8'h28);
    settle(2);
    chk_rd(3'h2);
    end_of_test();
  end
endmodule
